// ===== hdl/pgcn_pkg.sv
// types shared by the port g block
package pgcn_pkg;
	typedef logic [15:0] pgcn_word_t;
	typedef logic [23:0] pgcn_cn_t;
	typedef enum logic [1:0] {PGCN_IDLE, PGCN_ACCESS} pgcn_apb_state_t;
endpackage

// ===== hdl/pgcn_regs.svh
// register offsets, field masks and reset values of the port g block
`ifndef PGCN_REGS_SVH
`define PGCN_REGS_SVH
`define PGCN_OFF_DIR      12'h000
`define PGCN_OFF_PINS     12'h004
`define PGCN_OFF_LAT      12'h008
`define PGCN_OFF_CIE_LO   12'h00C
`define PGCN_OFF_CIE_HI   12'h010
`define PGCN_OFF_CPU_LO   12'h014
`define PGCN_OFF_CPU_HI   12'h018
`define PGCN_OFF_STAT     12'h01C
`define PGCN_OFF_MASK     12'h020
`define PGCN_PORT_MASK    16'hF3CF
`define PGCN_HI_MASK      16'h00FF
`define PGCN_DIR_RESET    16'hF3CF
`define PGCN_OE_RESET     16'hFFFF
`define PGCN_ZERO16       16'h0000
`define PGCN_ZERO24       24'h000000
`define PGCN_ZERO32       32'h00000000
`define PGCN_ADDR_MSB     11
`define PGCN_CN_LO_W      16
`define PGCN_CN_HI_LSB    16
`define PGCN_CN_MSB       23
`endif

// ===== hdl/pgcn_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pgcn_sync
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ===== hdl/pgcn_top.sv
// port g registers, change notification enables and pull-ups over apb
`timescale 1ns/1ps
`include "pgcn_regs.svh"
// How it works
// [RL1] direction one makes pin input, zero drives pin from output latch
// [RL2] all implemented direction bits reset to one, pins start as inputs
// [RL3] only bits 15-12, 9-6, 3-0 exist; others read zero
// [RL4] pins read returns live pin level; pins write loads output latch
// [RL5] pins read after reset follows external levels, no stored value
// [RL6] latch register reads stored latch, implemented bits reset zero
// [RL7] 24 change interrupt enables, 16 low register, 8 high register
// [RL8] zero enable blocks that input's change interrupt; reset zero
// [RL9] 24 pull-up enables split likewise; one turns pull-up on
// [RL10] high enable and pull-up registers bits 15-8 read zero
// [RL11] writes to unimplemented bits are dropped, nothing stored
// [RL12] enabled input differing from last sample raises change request
module pgcn_top
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] pin_in,
	output logic      [15:0] pin_out,
	output logic      [15:0] pin_oe_n,
	input  wire logic [23:0] cn_in,
	output logic      [23:0] cn_pullup,
	output logic             cn_request,
	output logic             irq
);
	pgcn_pkg::pgcn_word_t      dir_reg;
	pgcn_pkg::pgcn_word_t      lat_reg;
	pgcn_pkg::pgcn_cn_t        cie_reg;
	pgcn_pkg::pgcn_cn_t        cpu_reg;
	pgcn_pkg::pgcn_cn_t        stat_reg;
	pgcn_pkg::pgcn_cn_t        mask_reg;
	pgcn_pkg::pgcn_cn_t        cn_prev_reg;
	logic                      cn_armed_reg;
	logic [1:0]                cn_warm_reg;
	pgcn_pkg::pgcn_word_t      pin_sync;
	pgcn_pkg::pgcn_cn_t        cn_sync;
	pgcn_pkg::pgcn_cn_t        cn_event;
	pgcn_pkg::pgcn_apb_state_t state_reg;
	logic                      wr_en;
	logic                      rd_en;
	logic                      hit;
	logic [31:0]               rdata_next;
	pgcn_pkg::pgcn_word_t      wlo;

	pgcn_sync #(.WIDTH(16)) u_pin_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	pgcn_sync #(.WIDTH(24)) u_cn_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cn_in),
		.sync_out (cn_sync)
	);

	// access phase completes in the cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= pgcn_pkg::PGCN_IDLE;
		else
		begin
			case (state_reg)
				pgcn_pkg::PGCN_IDLE:
					if (psel && !penable)
						state_reg <= pgcn_pkg::PGCN_ACCESS;
				pgcn_pkg::PGCN_ACCESS:
					state_reg <= pgcn_pkg::PGCN_IDLE;
				default:
					state_reg <= pgcn_pkg::PGCN_IDLE;
			endcase
		end
	end

	assign wr_en = (state_reg == pgcn_pkg::PGCN_IDLE) && psel && !penable
		&& pwrite;
	assign rd_en = (state_reg == pgcn_pkg::PGCN_IDLE) && psel && !penable
		&& !pwrite;
	assign wlo = {pstrb[1] ? pwdata[15:8] : 8'h00,
		pstrb[0] ? pwdata[7:0] : 8'h00};

	always_comb
	begin
		hit = 1'b1;
		rdata_next = `PGCN_ZERO32;
		case (paddr)
			`PGCN_OFF_DIR:    rdata_next[15:0] = dir_reg;
			`PGCN_OFF_PINS:   rdata_next[15:0] = pin_sync & `PGCN_PORT_MASK; // RL4 RL5
			`PGCN_OFF_LAT:    rdata_next[15:0] = lat_reg; // RL6
			`PGCN_OFF_CIE_LO: rdata_next[15:0] = cie_reg[15:0];
			`PGCN_OFF_CIE_HI: rdata_next[7:0]  = cie_reg[23:16]; // RL10
			`PGCN_OFF_CPU_LO: rdata_next[15:0] = cpu_reg[15:0];
			`PGCN_OFF_CPU_HI: rdata_next[7:0]  = cpu_reg[23:16]; // RL10
			`PGCN_OFF_STAT:   rdata_next[23:0] = stat_reg;
			`PGCN_OFF_MASK:   rdata_next[23:0] = mask_reg;
			default:          hit = 1'b0;
		endcase
	end

	// read data and answer are registered during the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= `PGCN_ZERO32;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			if (rd_en)
				prdata <= rdata_next;
			else
				prdata <= `PGCN_ZERO32;
		end
	end

	// port g direction and latch; both pins and latch offsets load latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dir_reg <= `PGCN_DIR_RESET; // RL2
			lat_reg <= `PGCN_ZERO16; // RL6
		end
		else if (wr_en)
		begin
			if (paddr == `PGCN_OFF_DIR)
				dir_reg <= wlo & `PGCN_PORT_MASK; // RL3 RL11
			if (paddr == `PGCN_OFF_PINS || paddr == `PGCN_OFF_LAT)
				lat_reg <= wlo & `PGCN_PORT_MASK; // RL4 RL11
		end
	end

	// change enables, pull-ups and interrupt mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cie_reg <= `PGCN_ZERO24; // RL8
			cpu_reg <= `PGCN_ZERO24; // RL9
			mask_reg <= `PGCN_ZERO24;
		end
		else if (wr_en)
		begin
			case (paddr)
				`PGCN_OFF_CIE_LO: cie_reg[15:0] <= wlo; // RL7
				`PGCN_OFF_CIE_HI: cie_reg[23:16] <= wlo[7:0]; // RL7 RL11
				`PGCN_OFF_CPU_LO: cpu_reg[15:0] <= wlo; // RL9
				`PGCN_OFF_CPU_HI: cpu_reg[23:16] <= wlo[7:0]; // RL9 RL11
				`PGCN_OFF_MASK:
					mask_reg <= {pstrb[2] ? pwdata[23:16] : 8'h00, wlo};
				default: ;
			endcase
		end
	end

	// change detection against previous sample
	assign cn_event = (cn_sync ^ cn_prev_reg) & cie_reg
		& {24{cn_armed_reg}}; // RL8 RL12

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cn_prev_reg  <= `PGCN_ZERO24;
			cn_warm_reg  <= 2'h0;
			cn_armed_reg <= 1'b0;
			cn_request   <= 1'b0;
		end
		else
		begin
			cn_prev_reg  <= cn_sync;
			// arm only once the synchroniser holds real input levels
			cn_warm_reg  <= {cn_warm_reg[0], 1'b1};
			cn_armed_reg <= cn_warm_reg[1];
			cn_request   <= |cn_event; // RL12
		end
	end

	// sticky status, write one clears, new event wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_reg <= `PGCN_ZERO24;
		else if (wr_en && paddr == `PGCN_OFF_STAT)
			stat_reg <= (stat_reg & ~{pstrb[2] ? pwdata[23:16] : 8'h00, wlo})
				| cn_event;
		else
			stat_reg <= stat_reg | cn_event;
	end

	// pins, pull-ups and interrupt all from flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out   <= `PGCN_ZERO16;
			pin_oe_n  <= `PGCN_OE_RESET;
			cn_pullup <= `PGCN_ZERO24;
			irq       <= 1'b0;
		end
		else
		begin
			pin_out   <= lat_reg; // RL1
			pin_oe_n  <= dir_reg | ~`PGCN_PORT_MASK; // RL1 RL3
			cn_pullup <= cpu_reg; // RL9
			irq       <= |(stat_reg & mask_reg);
		end
	end

	AST_DIR_RESET: assert property (@(posedge pclk) // RL2
		$rose(presetn)
		|-> dir_reg == `PGCN_DIR_RESET)
		else $error("direction not all inputs after reset");

	AST_UNIMPL_ZERO: assert property (@(posedge pclk) // RL3
		disable iff (!presetn)
		((dir_reg | lat_reg) & ~`PGCN_PORT_MASK) == `PGCN_ZERO16)
		else $error("unimplemented port bit stored");

	AST_PIN_DRIVE: assert property (@(posedge pclk) // RL1
		disable iff (!presetn)
		##1 pin_oe_n == ($past(dir_reg) | ~`PGCN_PORT_MASK)
		&& pin_out == $past(lat_reg))
		else $error("pin drive does not follow direction and latch");

	AST_PINS_WRITE: assert property (@(posedge pclk) // RL4
		disable iff (!presetn)
		wr_en && paddr == `PGCN_OFF_PINS && pstrb[1:0] == 2'h3
		|=> lat_reg == ($past(pwdata[15:0]) & `PGCN_PORT_MASK))
		else $error("pins write did not load latch");

	AST_HI_ZERO: assert property (@(posedge pclk) // RL10
		disable iff (!presetn)
		$past(rd_en) && ($past(paddr) == `PGCN_OFF_CIE_HI
		|| $past(paddr) == `PGCN_OFF_CPU_HI)
		|-> prdata[31:8] == 24'h000000)
		else $error("high enable register upper bits not zero");

	AST_CN_BLOCK: assert property (@(posedge pclk) // RL8
		disable iff (!presetn)
		cie_reg == `PGCN_ZERO24 |=> !cn_request)
		else $error("change request while all enables clear");

	AST_CN_REQ: assert property (@(posedge pclk) // RL12
		disable iff (!presetn)
		cn_armed_reg && |((cn_sync ^ cn_prev_reg) & cie_reg)
		|=> cn_request ##0 (stat_reg != `PGCN_ZERO24))
		else $error("enabled change not signalled");

	AST_PULLUP: assert property (@(posedge pclk) // RL9
		disable iff (!presetn)
		##1 cn_pullup == $past(cpu_reg))
		else $error("pull-up outputs do not follow enables");

	AST_READY: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("apb answer not given after setup");

	AST_LAT_RESET: assert property (@(posedge pclk) // RL6
		$rose(presetn)
		|-> lat_reg == `PGCN_ZERO16)
		else $error("latch not clear after reset");

	AST_CIE_RESET: assert property (@(posedge pclk) // RL8
		$rose(presetn)
		|-> cie_reg == `PGCN_ZERO24)
		else $error("change enables not clear after reset");

	AST_CPU_RESET: assert property (@(posedge pclk) // RL9
		$rose(presetn)
		|-> cpu_reg == `PGCN_ZERO24 && cn_pullup == `PGCN_ZERO24)
		else $error("pull-ups not off after reset");

	AST_OE_UNIMPL: assert property (@(posedge pclk) // RL3
		disable iff (!presetn)
		(pin_oe_n & ~`PGCN_PORT_MASK) == ~`PGCN_PORT_MASK)
		else $error("unimplemented pin driven");

	AST_DIR_WRITE: assert property (@(posedge pclk) // RL1
		disable iff (!presetn)
		wr_en && paddr == `PGCN_OFF_DIR && pstrb[1:0] == 2'h3
		|=> dir_reg == ($past(pwdata[15:0]) & `PGCN_PORT_MASK))
		else $error("direction write not stored");

	AST_LAT_WRITE: assert property (@(posedge pclk) // RL6
		disable iff (!presetn)
		wr_en && paddr == `PGCN_OFF_LAT && pstrb[1:0] == 2'h3
		|=> lat_reg == ($past(pwdata[15:0]) & `PGCN_PORT_MASK))
		else $error("latch write not stored");

	AST_PINS_READ: assert property (@(posedge pclk) // RL4
		disable iff (!presetn)
		rd_en && paddr == `PGCN_OFF_PINS
		|=> prdata == {16'h0000, $past(pin_sync) & `PGCN_PORT_MASK})
		else $error("pins read not the pin levels");

	AST_LAT_READ: assert property (@(posedge pclk) // RL6
		disable iff (!presetn)
		rd_en && paddr == `PGCN_OFF_LAT
		|=> prdata == {16'h0000, $past(lat_reg)})
		else $error("latch read not the latch");

	AST_CIE_WRITE: assert property (@(posedge pclk) // RL7
		disable iff (!presetn)
		wr_en && paddr == `PGCN_OFF_CIE_LO && pstrb[1:0] == 2'h3
		|=> cie_reg[15:0] == $past(pwdata[15:0]))
		else $error("low change enables not stored");

	AST_CIE_HI_WRITE: assert property (@(posedge pclk) // RL11
		disable iff (!presetn)
		wr_en && paddr == `PGCN_OFF_CIE_HI && pstrb[0]
		|=> cie_reg[23:16] == $past(pwdata[7:0]))
		else $error("high change enables not stored");

	AST_CN_ENABLED: assert property (@(posedge pclk) // RL8
		disable iff (!presetn)
		##1 (stat_reg & ~$past(stat_reg) & ~$past(cie_reg))
		== `PGCN_ZERO24)
		else $error("status set for a disabled change input");

	AST_CN_QUIET: assert property (@(posedge pclk) // RL12
		disable iff (!presetn)
		cn_sync == cn_prev_reg |=> !cn_request)
		else $error("change request with no change");

	AST_NO_STRAY_WRITE: assert property (@(posedge pclk) // RL11
		disable iff (!presetn)
		psel && !penable && pwrite && !hit
		|=> $stable(dir_reg) && $stable(lat_reg) && $stable(cie_reg)
		&& $stable(cpu_reg) && $stable(mask_reg))
		else $error("write to an unmapped offset stored");

	AST_IRQ: assert property (@(posedge pclk)
		disable iff (!presetn)
		##1 irq == |($past(stat_reg) & $past(mask_reg)))
		else $error("interrupt does not follow status and mask");

	AST_SLVERR: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable && !hit |=> pslverr && pready)
		else $error("unmapped access not answered with error");
endmodule

// ===== verification/pgcn_pins.sv
// board side of port g: pins, pull-ups and change inputs
`timescale 1ns/1ps
module pgcn_pins
(
	input  wire logic        pclk,
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [23:0] cn_pullup,
	input  wire logic [15:0] ext_pins,
	input  wire logic [23:0] ext_cn,
	input  wire logic [23:0] cn_drive,
	output logic      [15:0] pin_in,
	output logic      [23:0] cn_in
);
	// a driven pin shows its latch, a released one the board level
	assign pin_in = (pin_oe_n & ext_pins) | (~pin_oe_n & pin_out);
	// undriven inputs read low unless the pull-up holds them high
	assign cn_in = (cn_drive & ext_cn) | (~cn_drive & cn_pullup);
endmodule

// ===== verification/pgcn_top_test.sv
// self-checking bench of the port g block
`timescale 1ns/1ps
`include "pgcn_regs.svh"
module pgcn_top_test;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, cn_request, irq, er, seen;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [15:0] pin_in, pin_out, pin_oe_n, ext_pins = 16'h0000;
	logic [23:0] cn_in, cn_pullup, ext_cn = 24'h000000;
	logic [23:0] cn_drive = 24'hFFFFFF;
	int errors = 0, n_compared = 0;
	logic [11:0] ra [7] = '{`PGCN_OFF_DIR, `PGCN_OFF_DIR, `PGCN_OFF_LAT,
		`PGCN_OFF_CIE_LO, `PGCN_OFF_CIE_HI, `PGCN_OFF_CPU_LO,
		`PGCN_OFF_CPU_HI};
	logic [15:0] rw [7] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h5555,
		16'hFFFF, 16'hA5A5, 16'hFFFF};
	logic [15:0] re [7] = '{16'hF3CF, 16'h0000, 16'hF3CF, 16'h5555,
		16'h00FF, 16'hA5A5, 16'h00FF};
	always #12.5 pclk = ~pclk;
	pgcn_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .cn_in(cn_in),
		.cn_pullup(cn_pullup), .cn_request(cn_request), .irq(irq));
	pgcn_pins board (.pclk(pclk), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .cn_pullup(cn_pullup),
		.ext_pins(ext_pins), .ext_cn(ext_cn), .cn_drive(cn_drive),
		.pin_in(pin_in), .cn_in(cn_in));
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task watch();
		seen = 1'b0;
		repeat (8)
		begin
			@(posedge pclk);
			seen = seen | cn_request;
		end
	endtask
	task final_report();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#(25 * 6000);
		errors++;
		final_report();
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, ra[i], rw[i]);
			apb(1'b0, ra[i], 16'h0000);
			chk("reg", {16'h0000, re[i]}, rd);
		end
		chk("pin_oe_n", 32'h0C30, pin_oe_n);
		chk("pin_out", 32'hF3CF, pin_out);
		chk("cn_pullup", 32'hFFA5A5, cn_pullup);
		apb(1'b0, `PGCN_OFF_PINS, 16'h0000);
		chk("pins", 32'hF3CF, rd);
		apb(1'b1, `PGCN_OFF_PINS, 16'h1234);
		apb(1'b0, `PGCN_OFF_LAT, 16'h0000);
		chk("latch", 32'h1204, rd);
		apb(1'b1, `PGCN_OFF_DIR, 16'hFFFF);
		ext_pins <= 16'h5A5A;
		repeat (2) @(posedge pclk);
		apb(1'b0, `PGCN_OFF_PINS, 16'h0000);
		chk("pins", 32'h524A, rd);
		apb(1'b0, `PGCN_OFF_LAT, 16'h0000);
		chk("latch", 32'h1204, rd);
		apb(1'b0, 12'h024, 16'h0000);
		chk("pslverr", 32'h1, er);
		apb(1'b1, 12'h024, 16'hFFFF);
		chk("pslverr", 32'h1, er);
		apb(1'b1, `PGCN_OFF_MASK, 16'h0003);
		ext_cn[0] <= 1'b1;
		watch();
		chk("cn_request", 32'h1, seen);
		chk("irq", 32'h1, irq);
		ext_cn[1] <= 1'b1;
		watch();
		chk("cn_request", 32'h0, seen);
		apb(1'b0, `PGCN_OFF_STAT, 16'h0000);
		chk("status", 32'h1, rd);
		apb(1'b1, `PGCN_OFF_MASK, 16'h0000);
		apb(1'b0, `PGCN_OFF_STAT, 16'h0000);
		chk("irq", 32'h0, irq);
		apb(1'b1, `PGCN_OFF_STAT, 16'h0001);
		apb(1'b0, `PGCN_OFF_STAT, 16'h0000);
		chk("status", 32'h0, rd);
		cn_drive[2] <= 1'b0;
		watch();
		chk("cn_request", 32'h1, seen);
		apb(1'b1, `PGCN_OFF_CPU_LO, 16'h0000);
		watch();
		chk("cn_request", 32'h1, seen);
		apb(1'b0, `PGCN_OFF_STAT, 16'h0000);
		chk("status", 32'h4, rd);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("pin_oe_n", 32'hFFFF, pin_oe_n);
		apb(1'b0, `PGCN_OFF_DIR, 16'h0000);
		chk("dir", 32'hF3CF, rd);
		for (int i = 2; i < 7; i++)
		begin
			apb(1'b0, ra[i], 16'h0000);
			chk("reset", 32'h0, rd);
		end
		final_report();
	end
endmodule
